// file: aclirq_pkg.sv
package aclirq_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_ENGINE_SOURCE = 8'h17;
   localparam logic [7:0] IDX_WAKE_SLEEP_SOURCE = 8'h18;
   localparam logic [7:0] IDX_STATUS = 8'h19;
   localparam logic [7:0] IDX_LATCH_RELEASE = 8'h1A;
   localparam logic [7:0] IDX_CONTROL_ONE = 8'h1B;
   localparam logic [7:0] IDX_CONTROL_TWO = 8'h1C;
   localparam logic [7:0] IDX_CONTROL_FOUR = 8'h1E;
   localparam logic [7:0] IDX_CONTROL_FIVE = 8'h1F;
   localparam logic [7:0] IDX_INT_CTRL_ONE = 8'h22;
   localparam logic [7:0] IDX_INT_CTRL_TWO = 8'h23;
   localparam logic [7:0] IDX_INT_CTRL_THREE = 8'h24;
   localparam logic [7:0] IDX_WAKE_THRESHOLD = 8'h26;
   localparam logic [7:0] IDX_WAKE_TIMER = 8'h27;
   localparam logic [7:0] IDX_TILT_TIMER = 8'h28;
   localparam logic [7:0] IDX_SLEEP_TIMER = 8'h29;
   localparam logic [7:0] IDX_TAP_LOW_LIMIT = 8'h2C;
   localparam logic [7:0] IDX_TAP_HIGH_LIMIT = 8'h2D;
   localparam logic [7:0] IDX_FALL_THRESHOLD = 8'h32;
   localparam logic [7:0] IDX_FALL_DEBOUNCE = 8'h33;
   localparam logic [7:0] IDX_FALL_CONTROL = 8'h34;
   localparam logic [7:0] IDX_TILT_PERIOD = 8'h38;
   localparam logic [7:0] IDX_WAKE_PERIOD = 8'h39;
   localparam logic [7:0] IDX_TAP_PERIOD = 8'h3A;
   localparam logic [7:0] IDX_FALL_PERIOD = 8'h3B;

   // field positions
   localparam int BIT_TILT_ENABLE = 0;
   localparam int BIT_TAP_ENABLE = 2;
   localparam int BIT_SLEEP_RETURN_ENABLE = 0;
   localparam int BIT_WAKE_ENABLE = 1;
   localparam int BIT_MANUAL_SLEEP = 0;
   localparam int BIT_LATCH_OR_PULSE = 3;
   localparam int BIT_PIN_POLARITY = 4;
   localparam int BIT_PIN_ENABLE = 5;
   localparam int BIT_FALL_ENABLE = 7;
   localparam int BIT_STATUS_WAKE = 0;
   localparam int BIT_STATUS_PENDING = 4;
   localparam int BIT_SRC_TILT = 0;
   localparam int BIT_SRC_SINGLE_TAP = 2;
   localparam int BIT_SRC_DOUBLE_TAP = 3;
   localparam int BIT_SRC_FALL = 7;
   localparam int BIT_SRC_SLEEP_RETURN = 3;
   localparam int BIT_SRC_WAKE = 7;

   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_INT_CTRL_ONE = 8'h10;
   localparam logic [5:0] RST_AXIS_MASK = 6'h3F;
   localparam logic [7:0] RST_THRESHOLD = 8'h08;
   localparam logic [7:0] RST_TIMER = 8'h01;
   localparam logic [15:0] RST_PERIOD = 16'h0001;

   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int PULSE_NS = 50000;
   localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
   localparam int BASE_TICK_NS = 10000;
   localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;

endpackage : aclirq_pkg

// file: aclirq_persist.sv
`timescale 1ns/1ps
module aclirq_persist (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic base_tick,
   input wire logic [15:0] period,
   input wire logic [7:0] limit,
   input wire logic cond,
   output logic fire
);
   logic [15:0] div_reg;
   logic [7:0] count_reg;
   logic sample;

   // one sample per engine data period, counted in base ticks
   assign sample = base_tick && (div_reg + 16'h0001 >= period);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 16'h0000;
      end else if (base_tick) begin
         div_reg <= sample ? 16'h0000 : div_reg + 16'h0001;
      end
   end

   // fires once when the condition has held for limit samples, or for one sample when limit is zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 8'h00;
         fire <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (sample) begin
            if (!cond) begin
               count_reg <= 8'h00;
            end else if (count_reg != 8'hFF) begin
               count_reg <= count_reg + 8'h01;
               fire <= (count_reg + 8'h01 == limit) || (limit == 8'h00 && count_reg == 8'h00);
            end
         end
      end
   end
endmodule : aclirq_persist

// file: aclirq_top.sv
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module aclirq_top
   import aclirq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] accel_x,
   input wire logic [7:0] accel_y,
   input wire logic [7:0] accel_z,
   input wire logic [5:0] tilt_position,
   input wire logic tap_valid,
   input wire logic tap_double,
   input wire logic [5:0] tap_axis,
   input wire logic [7:0] tap_index,
   output logic int_pin,
   output logic awake
);
   import aclirq_pkg::*;

   logic [7:0] control_one_reg;
   logic [5:0] tilt_mask_reg;
   logic [7:0] control_four_reg;
   logic [7:0] int_ctrl_one_reg;
   logic [5:0] wake_axis_mask_reg;
   logic [5:0] tap_mask_reg;
   logic [7:0] wake_threshold_reg;
   logic [7:0] wake_timer_reg;
   logic [7:0] tilt_timer_reg;
   logic [7:0] sleep_timer_reg;
   logic [7:0] tap_low_limit_reg;
   logic [7:0] tap_index_high_limit;
   logic [7:0] fall_threshold_reg;
   logic [7:0] fall_debounce_count;
   logic [7:0] fall_control_reg;
   logic [15:0] tilt_period_reg;
   logic [15:0] wake_period_reg;
   logic [15:0] tap_period_reg;
   logic [15:0] fall_period_reg;
   logic [7:0] engine_source_reg;
   logic [7:0] wake_sleep_source_reg;
   logic wake_state_reg;
   logic [5:0] tilt_current_reg;
   logic [7:0] base_div_reg;
   logic base_tick;
   logic [9:0] pulse_cnt_reg;
   logic pin_active_reg;

   logic access;
   logic wr_done;
   logic rd_done;
   logic [7:0] reg_index;
   logic release_read;
   logic manual_sleep;
   logic mapped;
   logic [31:0] read_mux;
   logic pending;
   logic any_event;

   logic tilt_cond;
   logic wake_cond;
   logic sleep_cond;
   logic tap_cond;
   logic fall_cond;
   logic tilt_fire;
   logic wake_fire;
   logic sleep_fire;
   logic tap_fire;
   logic fall_fire;
   logic [5:0] axis_over;
   logic [5:0] tilt_allowed;

   // bus decode: one wait state, completion when pready is high
   assign access = psel && penable && pready;
   assign wr_done = access && pwrite;
   assign rd_done = access && !pwrite;
   assign reg_index = paddr[9:2];
   assign release_read = rd_done && reg_index == IDX_LATCH_RELEASE && paddr[11:10] == 2'b00;
   assign manual_sleep = wr_done && reg_index == IDX_CONTROL_FIVE && pwdata[BIT_MANUAL_SLEEP];

   always_comb begin
      mapped = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00;
      read_mux = 32'h00000000;
      case (reg_index)
         IDX_ENGINE_SOURCE: read_mux[7:0] = engine_source_reg;
         IDX_WAKE_SLEEP_SOURCE: read_mux[7:0] = wake_sleep_source_reg;
         IDX_STATUS: begin
            read_mux[BIT_STATUS_PENDING] = pending;
            read_mux[BIT_STATUS_WAKE] = wake_state_reg;
         end
         IDX_LATCH_RELEASE: read_mux = 32'h00000000;
         IDX_CONTROL_ONE: read_mux[7:0] = control_one_reg;
         IDX_CONTROL_TWO: read_mux[5:0] = tilt_mask_reg;
         IDX_CONTROL_FOUR: read_mux[7:0] = control_four_reg;
         IDX_CONTROL_FIVE: read_mux = 32'h00000000;
         IDX_INT_CTRL_ONE: read_mux[7:0] = int_ctrl_one_reg;
         IDX_INT_CTRL_TWO: read_mux[5:0] = wake_axis_mask_reg;
         IDX_INT_CTRL_THREE: read_mux[5:0] = tap_mask_reg;
         IDX_WAKE_THRESHOLD: read_mux[7:0] = wake_threshold_reg;
         IDX_WAKE_TIMER: read_mux[7:0] = wake_timer_reg;
         IDX_TILT_TIMER: read_mux[7:0] = tilt_timer_reg;
         IDX_SLEEP_TIMER: read_mux[7:0] = sleep_timer_reg;
         IDX_TAP_LOW_LIMIT: read_mux[7:0] = tap_low_limit_reg;
         IDX_TAP_HIGH_LIMIT: read_mux[7:0] = tap_index_high_limit;
         IDX_FALL_THRESHOLD: read_mux[7:0] = fall_threshold_reg;
         IDX_FALL_DEBOUNCE: read_mux[7:0] = fall_debounce_count;
         IDX_FALL_CONTROL: read_mux[7:0] = fall_control_reg;
         IDX_TILT_PERIOD: read_mux[15:0] = tilt_period_reg;
         IDX_WAKE_PERIOD: read_mux[15:0] = wake_period_reg;
         IDX_TAP_PERIOD: read_mux[15:0] = tap_period_reg;
         IDX_FALL_PERIOD: read_mux[15:0] = fall_period_reg;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready) begin
            prdata <= (!pwrite && mapped) ? read_mux : 32'h00000000;
         end
      end
   end

   // configuration registers, written at the completing edge only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_one_reg <= RST_CONTROL;
         tilt_mask_reg <= RST_AXIS_MASK;
         control_four_reg <= RST_CONTROL;
         int_ctrl_one_reg <= RST_INT_CTRL_ONE;
         wake_axis_mask_reg <= RST_AXIS_MASK;
         tap_mask_reg <= RST_AXIS_MASK;
         wake_threshold_reg <= RST_THRESHOLD;
         wake_timer_reg <= RST_TIMER;
         tilt_timer_reg <= RST_TIMER;
         sleep_timer_reg <= RST_TIMER;
         tap_low_limit_reg <= RST_THRESHOLD;
         tap_index_high_limit <= RST_THRESHOLD;
         fall_threshold_reg <= RST_THRESHOLD;
         fall_debounce_count <= RST_TIMER;
         fall_control_reg <= RST_CONTROL;
         tilt_period_reg <= RST_PERIOD;
         wake_period_reg <= RST_PERIOD;
         tap_period_reg <= RST_PERIOD;
         fall_period_reg <= RST_PERIOD;
      end else if (wr_done && mapped) begin
         case (reg_index)
            IDX_CONTROL_ONE: control_one_reg <= pwdata[7:0];
            IDX_CONTROL_TWO: tilt_mask_reg <= pwdata[5:0];
            IDX_CONTROL_FOUR: control_four_reg <= pwdata[7:0];
            IDX_INT_CTRL_ONE: int_ctrl_one_reg <= pwdata[7:0];
            IDX_INT_CTRL_TWO: wake_axis_mask_reg <= pwdata[5:0];
            IDX_INT_CTRL_THREE: tap_mask_reg <= pwdata[5:0];
            IDX_WAKE_THRESHOLD: wake_threshold_reg <= pwdata[7:0];
            IDX_WAKE_TIMER: wake_timer_reg <= pwdata[7:0];
            IDX_TILT_TIMER: tilt_timer_reg <= pwdata[7:0];
            IDX_SLEEP_TIMER: sleep_timer_reg <= pwdata[7:0];
            IDX_TAP_LOW_LIMIT: tap_low_limit_reg <= pwdata[7:0];
            IDX_TAP_HIGH_LIMIT: tap_index_high_limit <= pwdata[7:0];
            IDX_FALL_THRESHOLD: fall_threshold_reg <= pwdata[7:0];
            IDX_FALL_DEBOUNCE: fall_debounce_count <= pwdata[7:0];
            IDX_FALL_CONTROL: fall_control_reg <= pwdata[7:0];
            IDX_TILT_PERIOD: tilt_period_reg <= pwdata[15:0];
            IDX_WAKE_PERIOD: wake_period_reg <= pwdata[15:0];
            IDX_TAP_PERIOD: tap_period_reg <= pwdata[15:0];
            IDX_FALL_PERIOD: fall_period_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // base tick shared by the per-engine rate dividers
   assign base_tick = base_div_reg == 8'(BASE_TICK_CYCLES - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_div_reg <= 8'h00;
      end else begin
         base_div_reg <= base_tick ? 8'h00 : base_div_reg + 8'h01;
      end
   end

   // engine conditions
   assign axis_over = {accel_z > wake_threshold_reg, accel_z > wake_threshold_reg,
                       accel_y > wake_threshold_reg, accel_y > wake_threshold_reg,
                       accel_x > wake_threshold_reg, accel_x > wake_threshold_reg};
   assign tilt_allowed = tilt_position & tilt_mask_reg;
   assign tilt_cond = control_one_reg[BIT_TILT_ENABLE] && tilt_allowed != 6'h00
                      && tilt_allowed != tilt_current_reg;
   assign wake_cond = control_four_reg[BIT_WAKE_ENABLE] && !wake_state_reg
                      && (axis_over & wake_axis_mask_reg) != 6'h00;
   assign sleep_cond = control_four_reg[BIT_SLEEP_RETURN_ENABLE] && wake_state_reg
                       && (axis_over & wake_axis_mask_reg) == 6'h00;
   assign tap_cond = control_one_reg[BIT_TAP_ENABLE] && tap_valid
                     && (tap_axis & tap_mask_reg) != 6'h00
                     && tap_index >= tap_low_limit_reg
                     && tap_index <= tap_index_high_limit;
   assign fall_cond = fall_control_reg[BIT_FALL_ENABLE] && accel_x < fall_threshold_reg
                      && accel_y < fall_threshold_reg && accel_z < fall_threshold_reg;

   // each engine counts samples at its own data period, except sleep return, which uses the wake period
   aclirq_persist tilt_timer (
      .pclk(pclk),
      .presetn(presetn),
      .base_tick(base_tick),
      .period(tilt_period_reg),
      .limit(tilt_timer_reg),
      .cond(tilt_cond),
      .fire(tilt_fire)
   );

   aclirq_persist wake_detector (
      .pclk(pclk),
      .presetn(presetn),
      .base_tick(base_tick),
      .period(wake_period_reg),
      .limit(wake_timer_reg),
      .cond(wake_cond),
      .fire(wake_fire)
   );

   aclirq_persist sleep_timer (
      .pclk(pclk),
      .presetn(presetn),
      .base_tick(base_tick),
      .period(wake_period_reg),
      .limit(sleep_timer_reg),
      .cond(sleep_cond),
      .fire(sleep_fire)
   );

   // tap qualifies on a single sample of the tap rate
   aclirq_persist tap_detector (
      .pclk(pclk),
      .presetn(presetn),
      .base_tick(base_tick),
      .period(tap_period_reg),
      .limit(RST_TIMER),
      .cond(tap_cond),
      .fire(tap_fire)
   );

   aclirq_persist fall_timer (
      .pclk(pclk),
      .presetn(presetn),
      .base_tick(base_tick),
      .period(fall_period_reg),
      .limit(fall_debounce_count),
      .cond(fall_cond),
      .fire(fall_fire)
   );

   // current tilt position is recorded when the tilt fires; may lag a sample behind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tilt_current_reg <= 6'h00;
      end else if (tilt_fire) begin
         tilt_current_reg <= tilt_allowed;
      end
   end

   // sticky sources: a new event wins over a release in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         engine_source_reg <= 8'h00;
      end else begin
         engine_source_reg <= (release_read ? 8'h00 : engine_source_reg)
                              | (8'(tilt_fire) << BIT_SRC_TILT)
                              | (8'(tap_fire && !tap_double) << BIT_SRC_SINGLE_TAP)
                              | (8'(tap_fire && tap_double) << BIT_SRC_DOUBLE_TAP)
                              | (8'(fall_fire) << BIT_SRC_FALL);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_sleep_source_reg <= 8'h00;
      end else begin
         wake_sleep_source_reg <= (release_read ? 8'h00 : wake_sleep_source_reg)
                                  | (8'(wake_fire) << BIT_SRC_WAKE)
                                  | (8'(sleep_fire) << BIT_SRC_SLEEP_RETURN);
      end
   end

   // pending follows the sources, so release clears it too
   assign pending = engine_source_reg != 8'h00 || wake_sleep_source_reg != 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_state_reg <= 1'b0;
      end else if (wake_fire) begin
         wake_state_reg <= 1'b1;
      end else if (manual_sleep || sleep_fire) begin
         wake_state_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         awake <= 1'b0;
      end else begin
         awake <= wake_fire || (wake_state_reg && !manual_sleep && !sleep_fire);
      end
   end

   // pin event state: latched until release, or a fixed-length pulse
   assign any_event = tilt_fire || wake_fire || sleep_fire || tap_fire || fall_fire;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_active_reg <= 1'b0;
         pulse_cnt_reg <= 10'h000;
      end else if (int_ctrl_one_reg[BIT_LATCH_OR_PULSE]) begin
         // a new event restarts the pulse rather than queueing a second one
         if (any_event) begin
            pin_active_reg <= 1'b1;
            pulse_cnt_reg <= 10'(PULSE_CYCLES - 1);
         end else if (pulse_cnt_reg != 10'h000) begin
            pulse_cnt_reg <= pulse_cnt_reg - 10'h001;
         end else begin
            pin_active_reg <= 1'b0;
         end
      end else begin
         pulse_cnt_reg <= 10'h000;
         if (any_event) begin
            pin_active_reg <= 1'b1;
         end else if (release_read) begin
            pin_active_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // idle level of the reset config, so no false edge at the host
         int_pin <= ~RST_INT_CTRL_ONE[BIT_PIN_POLARITY];
      end else begin
         int_pin <= (int_ctrl_one_reg[BIT_PIN_ENABLE] && pin_active_reg)
                    == int_ctrl_one_reg[BIT_PIN_POLARITY];
      end
   end

endmodule : aclirq_top

// file: aclirq_top_sva.sv
`timescale 1ns/1ps
module aclirq_top_sva
   import aclirq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic int_pin,
   input wire logic awake
);
   logic [7:0] ictl_reg;
   logic wake_en_reg;
   logic [1:0] since_wr_reg;
   logic [1:0] since_rel_reg;
   logic [10:0] act_len_reg;
   logic wr_done;
   logic rel_done;
   logic cfg_ok;
   logic act;
   assign wr_done = psel && penable && pready && !pslverr && pwrite;
   assign rel_done = psel && penable && pready && !pwrite && paddr[9:2] == IDX_LATCH_RELEASE;
   // pin lags a config write by two edges, so judge only settled config
   assign cfg_ok = since_wr_reg == 2'h3 && !wr_done;
   assign act = int_pin == ictl_reg[BIT_PIN_POLARITY];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ictl_reg <= RST_INT_CTRL_ONE;
         wake_en_reg <= 1'b0;
      end else if (wr_done && paddr[9:2] == IDX_INT_CTRL_ONE) begin
         ictl_reg <= pwdata[7:0];
      end else if (wr_done && paddr[9:2] == IDX_CONTROL_FOUR) begin
         wake_en_reg <= pwdata[BIT_WAKE_ENABLE];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_wr_reg <= 2'h0;
      else if (wr_done) since_wr_reg <= 2'h0;
      else if (since_wr_reg != 2'h3) since_wr_reg <= since_wr_reg + 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_rel_reg <= 2'h0;
      else if (rel_done) since_rel_reg <= 2'h0;
      else if (since_rel_reg != 2'h3) since_rel_reg <= since_rel_reg + 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) act_len_reg <= 11'h000;
      else if (!act) act_len_reg <= 11'h000;
      else if (act_len_reg != 11'h7FF) act_len_reg <= act_len_reg + 11'h001;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_release;
      rel_done;
   endsequence
   sequence s_pulse_start;
      act && !$past(act) && cfg_ok && ictl_reg[BIT_LATCH_OR_PULSE] && ictl_reg[BIT_PIN_ENABLE];
   endsequence
   property p_release_data;
      s_release |-> prdata == 32'h0;
   endproperty
   property p_latch_hold;
      cfg_ok && since_rel_reg == 2'h3 && !rel_done && act && ictl_reg[5] && !ictl_reg[3] |=> act;
   endproperty
   property p_pulse_min;
      s_pulse_start |-> act [*8];
   endproperty
   property p_pulse_max;
      cfg_ok && ictl_reg[BIT_LATCH_OR_PULSE] |-> act_len_reg <= 11'h3EB;
   endproperty
   property p_disabled_idle;
      cfg_ok && !ictl_reg[BIT_PIN_ENABLE] |-> int_pin == !ictl_reg[BIT_PIN_POLARITY];
   endproperty
   property p_disabled_still;
      cfg_ok && !ictl_reg[BIT_PIN_ENABLE] |=> $stable(int_pin);
   endproperty
   property p_forced_sleep;
      wr_done && paddr[9:2] == IDX_CONTROL_FIVE && pwdata[BIT_MANUAL_SLEEP] |-> ##[1:3] !awake;
   endproperty
   property p_wake_gated;
      cfg_ok && !wake_en_reg && !awake |=> !awake;
   endproperty
   a_release_data: assert property (p_release_data) else $error("release data not zero");
   a_latch_hold: assert property (p_latch_hold) else $error("latched pin dropped");
   a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
   a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
   a_disabled_idle: assert property (p_disabled_idle) else $error("disabled pin not idle");
   a_disabled_still: assert property (p_disabled_still) else $error("disabled pin moved");
   a_forced_sleep: assert property (p_forced_sleep) else $error("still awake");
   a_wake_gated: assert property (p_wake_gated) else $error("woke while disabled");
endmodule : aclirq_top_sva
bind aclirq_top aclirq_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .int_pin(int_pin), .awake(awake));

// file: aclirq_host_gpio.sv
`timescale 1ns/1ps
module aclirq_host_gpio (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic int_pin,
   input wire logic active_high,
   output logic [7:0] irq_count
);
   logic gpio_en_reg;
   logic last_reg;
   logic hit;
   // edge catch only, no bus traffic from the handler
   assign hit = gpio_en_reg && int_pin == active_high && last_reg != active_high;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_en_reg <= 1'b1;
         last_reg <= 1'b1;
         irq_count <= 8'h00;
      end else begin
         last_reg <= int_pin;
         gpio_en_reg <= !hit;
         if (hit) irq_count <= irq_count + 8'h01;
      end
   end
endmodule : aclirq_host_gpio

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import aclirq_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] accel_x = 8'h00;
   logic tap_valid = 1'b0;
   logic tap_double = 1'b0;
   logic host_pol = 1'b1;
   logic int_pin;
   logic awake;
   logic [7:0] irq_count;
   logic [31:0] rdv;
   logic errv;
   int n_mismatch = 0;
   int num_checks = 0;
   always #25 pclk = ~pclk;
   aclirq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .accel_x(accel_x), .accel_y(8'h00), .accel_z(8'h00), .tilt_position(6'h00), .tap_valid(tap_valid),
      .tap_double(tap_double), .tap_axis(6'h01), .tap_index(8'h08), .int_pin(int_pin), .awake(awake));
   aclirq_host_gpio u_host (.pclk(pclk), .presetn(presetn), .int_pin(int_pin), .active_high(host_pol),
      .irq_count(irq_count));
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            chk(32'h0, 32'h1, "apb timeout");
            close_out();
         end
         @(posedge pclk);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 32'h0);
      chk(rdv, exp, what);
   endtask : rd
   task automatic wait_on(input bit sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while ((sel ? awake : int_pin) !== lvl) begin
         n++;
         if (n > lim) begin
            chk(32'h0, 32'h1, "wait timeout");
            close_out();
         end
         @(posedge pclk);
      end
   endtask : wait_on
   task automatic hold(input bit sel, input logic lvl, input int cyc, input string what);
      int bad;
      bad = 0;
      repeat (cyc) begin
         @(posedge pclk);
         if ((sel ? awake : int_pin) !== lvl) bad++;
      end
      chk(bad, 32'h0, what);
   endtask : hold
   task automatic t_tap_latched;
      rd(IDX_INT_CTRL_ONE, 32'h10, "ictl reset");
      apb(1'b1, IDX_INT_CTRL_ONE, 32'h30);
      tap_valid <= 1'b1;
      hold(0, 1'b0, 600, "tap off");
      rd(IDX_ENGINE_SOURCE, 32'h0, "tap off src");
      for (int d = 0; d < 2; d++) begin
         tap_double <= d[0];
         tap_valid <= 1'b1;
         apb(1'b1, IDX_CONTROL_ONE, 32'h04);
         wait_on(0, 1'b1, 600);
         tap_valid <= 1'b0;
         apb(1'b1, IDX_CONTROL_ONE, 32'h00);
         hold(0, 1'b1, 300, "latched pin");
         rd(IDX_STATUS, 32'h10, "pending");
         rd(IDX_ENGINE_SOURCE, d ? 32'h08 : 32'h04, "tap src");
         rd(IDX_LATCH_RELEASE, 32'h0, "release");
         wait_on(0, 1'b0, 4);
         rd(IDX_STATUS, 32'h0, "pending clr");
         rd(IDX_ENGINE_SOURCE, 32'h0, "src clr");
      end
      chk({24'h0, irq_count}, 32'h2, "host irqs");
   endtask : t_tap_latched
   task automatic t_pulse;
      int n;
      n = 0;
      host_pol <= 1'b0;
      apb(1'b1, IDX_INT_CTRL_ONE, 32'h28);
      hold(0, 1'b1, 5, "low idle");
      apb(1'b1, IDX_CONTROL_ONE, 32'h04);
      tap_valid <= 1'b1;
      wait_on(0, 1'b0, 600);
      tap_valid <= 1'b0;
      while (int_pin === 1'b0 && n < 1100) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, n >= PULSE_CYCLES - 2 && n <= PULSE_CYCLES + 2}, 32'h1, "pulse len");
      chk({24'h0, irq_count}, 32'h3, "host irqs");
      apb(1'b1, IDX_CONTROL_ONE, 32'h00);
      rd(IDX_LATCH_RELEASE, 32'h0, "release");
   endtask : t_pulse
   task automatic t_disabled;
      apb(1'b1, IDX_INT_CTRL_ONE, 32'h10);
      apb(1'b1, IDX_CONTROL_ONE, 32'h04);
      tap_valid <= 1'b1;
      hold(0, 1'b0, 500, "disabled pin");
      tap_valid <= 1'b0;
      apb(1'b1, IDX_CONTROL_ONE, 32'h00);
      rd(IDX_STATUS, 32'h10, "hidden pending");
      rd(IDX_LATCH_RELEASE, 32'h0, "release");
      rd(IDX_STATUS, 32'h0, "pending clr");
   endtask : t_disabled
   task automatic t_wake;
      accel_x <= 8'h20;
      hold(1, 1'b0, 500, "wake off");
      apb(1'b1, IDX_CONTROL_FOUR, 32'h02);
      wait_on(1, 1'b1, 800);
      accel_x <= 8'h00;
      rd(IDX_WAKE_SLEEP_SOURCE, 32'h80, "wake src");
      apb(1'b1, IDX_CONTROL_FIVE, 32'h01);
      wait_on(1, 1'b0, 3);
      rd(IDX_STATUS, 32'h10, "wake flag");
      rd(IDX_LATCH_RELEASE, 32'h0, "release");
      rd(IDX_WAKE_SLEEP_SOURCE, 32'h0, "wake src clr");
   endtask : t_wake
   task automatic t_fall;
      apb(1'b1, IDX_FALL_DEBOUNCE, 32'h03);
      apb(1'b1, IDX_FALL_CONTROL, 32'h80);
      // three samples at 200 cycles each: none can have fired by 300
      repeat (300) @(posedge pclk);
      rd(IDX_ENGINE_SOURCE, 32'h0, "fall early");
      repeat (400) @(posedge pclk);
      rd(IDX_ENGINE_SOURCE, 32'h80, "fall src");
      apb(1'b1, IDX_FALL_CONTROL, 32'h00);
      rd(IDX_LATCH_RELEASE, 32'h0, "release");
   endtask : t_fall
   task automatic t_unmapped;
      apb(1'b1, 8'h00, 32'hFF);
      chk({31'h0, errv}, 32'h1, "unmapped wr");
      rd(8'h00, 32'h0, "unmapped data");
      chk({31'h0, errv}, 32'h1, "unmapped rd");
   endtask : t_unmapped
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_unmapped();
      t_tap_latched();
      t_pulse();
      t_disabled();
      t_wake();
      t_fall();
      close_out();
   end
endmodule : tb_top
